// *** rtl/timer_pwm_ppg_output.sv ***
// Purpose: PWM and programmable_pulse output control of a 16-bit timer.
// Assumes: Software keeps to the documented mode settings and limits.
// Notes: Two pins driven from count matches against two compare values.
//
// Contract
// RULE1 - PWM period is one full count wrap; compare_a/b set widths.
// RULE2 - Software clears the clear and mode-select bits before PWM.
// RULE3 - Narrow width: PWM period lasts 256 count clocks.
// RULE4 - Wide width: PWM period lasts 65,536 count clocks.
// RULE5 - Width is compare times count clock; clock is clk over 8..2048.
// RULE6 - Software never loads zero into a compare during PWM.
// RULE7 - PWM output changes at most once per period on its match.
// RULE8 - Compare below current count gives full-period active output.
// RULE9 - Software rewrites a PWM compare from its own match interrupt.
// RULE10 - Stopping the counter drives the output to its active level.
// RULE11 - Disabled output shows the inverse of its level select.
// RULE12 - Pulse mode: out_a only, period compare_b+1, width compare_a.
// RULE13 - Software sets clear_on_compare_b, clears the rest, for pulses.
// RULE14 - Pulse mode: 1 <= compare_a <= compare_b, no zero compares.
// RULE15 - Pulse mode: out_a changes once per period at compare_a.
// RULE16 - compare_a at or below count before match gives full duty.
// RULE17 - compare_b below count stretches period to a full wrap.
// RULE18 - compare_b rewrite after match keeps inactive until overflow.
// RULE19 - compare_b rewrite before match: active, match, then overflow.
// RULE20 - Software rewrites compare_b from its own match interrupt.
// RULE21 - For short periods software polls flags with interrupts masked.
// RULE22 - Disabled output is high for select 0, low for select 1.
// RULE23 - PWM output goes active at zero and inactive on its match.
// RULE24 - Pulse mode clears count after compare_b match; out_a active.
// RULE25 - Separate interrupt requests on compare_a and compare_b match.
//
// Design decisions made here: the register addresses and the plain strobed port.
module timer_pwm_ppg_output
    import pwm_ppg_pkg::*;
(
    input wire logic clk,                 // 25 MHz system clock
    input wire logic rst_b,               // Async reset, active low
    input wire reg_req_t req,             // Register access request
    output logic [DATA_W-1:0] rdata,      // Read data, cycle after read
    output logic out_a,                   // Timer output pin A
    output logic out_b,                   // Timer output pin B
    output logic match_a_irq,             // compare_a match pulse
    output logic match_b_irq              // compare_b match pulse
);

    typedef struct packed {
        ctrl_t ctrl;
        mode_t mode;
        logic [CNT_W-1:0] compare_a;
        logic [CNT_W-1:0] compare_b;
        logic [CNT_W-1:0] timer_count;
        logic act_a;
        logic act_b;
        logic done_a;
        logic done_b;
        logic out_a;
        logic out_b;
        logic irq_a;
        logic irq_b;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic tick;
    logic [CNT_W-1:0] cmp_a_m;
    logic [CNT_W-1:0] cmp_b_m;
    logic [CNT_W-1:0] count_next;

    count_prescaler u_prescaler (
        .clk(clk),
        .rst_b(rst_b),
        .run(state_q.ctrl.count_run),
        .sel(state_q.ctrl.prescale_sel),
        .tick(tick)
    );

    // Compares folded to the active counter width
    assign cmp_a_m = width_mask(state_q.compare_a,
                                state_q.ctrl.count_width_select);
    assign cmp_b_m = width_mask(state_q.compare_b,
                                state_q.ctrl.count_width_select);

    always_comb begin
        state_d = state_q;
        state_d.irq_a = 1'b0;
        state_d.irq_b = 1'b0;
        state_d.rdata = '0;
        count_next = state_q.timer_count;

        // Register writes
        if (req.wr) begin
            unique case (req.addr)
                OFF_CTRL: begin
                    state_d.ctrl = ctrl_t'(req.wdata[CTRL_W-1:0]);
                end
                OFF_CMP_A: begin
                    state_d.compare_a = req.wdata[CNT_W-1:0];
                end
                OFF_CMP_B: begin
                    state_d.compare_b = req.wdata[CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, unmapped reads return zero
        if (req.rd) begin
            unique case (req.addr)
                OFF_CTRL: begin
                    state_d.rdata = DATA_W'(state_q.ctrl);
                end
                OFF_CMP_A: begin
                    state_d.rdata = DATA_W'(state_q.compare_a);
                end
                OFF_CMP_B: begin
                    state_d.rdata = DATA_W'(state_q.compare_b);
                end
                OFF_STATUS: begin
                    state_d.rdata = DATA_W'(state_q.timer_count);
                    state_d.rdata[STAT_ACT_A] = state_q.act_a;
                    state_d.rdata[STAT_ACT_B] = state_q.act_b;
                end
                default: begin
                end
            endcase
        end

        // Mode follows run and the clear-on-compare_b setting
        if (!state_q.ctrl.count_run) begin
            state_d.mode = MODE_IDLE;
        end else if (state_q.ctrl.clear_on_compare_b) begin
            state_d.mode = MODE_PULSE;
        end else begin
            state_d.mode = MODE_PWM;
        end

        unique case (state_q.mode)
            MODE_IDLE: begin
                // Stopped: counter parked, outputs at active level
                state_d.timer_count = CNT_ZERO;
                state_d.act_a = 1'b1;                        // see RULE10
                state_d.act_b = 1'b1;                        // see RULE10
                state_d.done_a = 1'b0;
                state_d.done_b = 1'b0;
            end
            MODE_PWM, MODE_PULSE: begin
                if (tick) begin                              // see RULE5
                    if (state_q.mode == MODE_PULSE &&
                        state_q.timer_count == cmp_b_m) begin
                        count_next = CNT_ZERO;               // see RULE24
                    end else begin
                        // Full wrap at 8 or 16 bits
                        count_next = width_mask(             // see RULE1
                            state_q.timer_count + CNT_STEP,  // see RULE3
                            state_q.ctrl.count_width_select);// see RULE4
                    end
                    state_d.timer_count = count_next;
                    state_d.irq_a = (count_next == cmp_a_m); // see RULE25
                    state_d.irq_b = (count_next == cmp_b_m); // see RULE25
                    // A lowered compare_b is missed: period runs to wrap
                    if (count_next == CNT_ZERO) begin        // see RULE17
                        state_d.act_a = 1'b1;                // see RULE23
                        state_d.done_a = 1'b0;               // see RULE18
                        state_d.act_b = (state_q.mode == MODE_PWM);
                        state_d.done_b = 1'b0;
                    end
                    // One change per period, later matches ignored
                    if (count_next == cmp_a_m &&
                        !state_d.done_a) begin               // see RULE7
                        state_d.act_a = 1'b0;                // see RULE15
                        state_d.done_a = 1'b1;               // see RULE19
                    end
                    if (state_q.mode == MODE_PWM &&
                        count_next == cmp_b_m &&
                        !state_d.done_b) begin               // see RULE7
                        state_d.act_b = 1'b0;                // see RULE23
                        state_d.done_b = 1'b1;
                    end
                end
                // Pulse mode drives only out_a
                if (state_q.mode == MODE_PULSE) begin        // see RULE12
                    state_d.act_b = 1'b0;
                end
            end
            default: begin
                state_d.mode = MODE_IDLE;
            end
        endcase

        // Compare behind the count: no match until wrap, full duty
        state_d.out_a = pin_level(state_q.ctrl.output_enable_a, // see RULE11
                                  state_q.ctrl.active_level_a,  // see RULE22
                                  state_d.act_a);               // see RULE8
        state_d.out_b = pin_level(state_q.ctrl.output_enable_b, // see RULE11
                                  state_q.ctrl.active_level_b,  // see RULE22
                                  state_d.act_b);               // see RULE16
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
            state_q.out_a <= OUT_RST;
            state_q.out_b <= OUT_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata = state_q.rdata;
    assign out_a = state_q.out_a;
    assign out_b = state_q.out_b;
    assign match_a_irq = state_q.irq_a;
    assign match_b_irq = state_q.irq_b;

    // Checks
    chk_disabled_level: assert property ( // see RULE22
        @(posedge clk) disable iff (!rst_b)
        !state_q.ctrl.output_enable_a
        |=> out_a == !$past(state_q.ctrl.active_level_a))
        else $error("disabled out_a not at fixed level");

    chk_stop_active: assert property ( // see RULE10
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_IDLE) && state_q.ctrl.output_enable_b
        |=> out_b == !$past(state_q.ctrl.active_level_b))
        else $error("stopped out_b not at active level");

    chk_pulse_clear: assert property ( // see RULE24
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_PULSE) && tick &&
        (state_q.timer_count == cmp_b_m)
        |=> state_q.timer_count == CNT_ZERO && state_q.act_a)
        else $error("pulse period did not restart after compare_b");

    chk_byte_wrap: assert property ( // see RULE3
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_PWM) && tick &&
        !state_q.ctrl.count_width_select &&
        (state_q.timer_count == BYTE_TOP)
        |=> state_q.timer_count == CNT_ZERO)
        else $error("narrow count did not wrap after 256 clocks");

    chk_word_wrap: assert property ( // see RULE4
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_PWM) && tick &&
        state_q.ctrl.count_width_select &&
        (state_q.timer_count == WORD_TOP)
        |=> state_q.timer_count == CNT_ZERO)
        else $error("wide count did not wrap after 65536 clocks");

    chk_tick_only: assert property ( // see RULE5
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode != MODE_IDLE) && (state_d.mode != MODE_IDLE) &&
        !tick
        |=> $stable(state_q.timer_count) && $stable(state_q.act_a))
        else $error("count or output moved without a count clock");

    chk_once_period: assert property ( // see RULE7
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode != MODE_IDLE) && state_q.done_a &&
        !(tick && count_next == CNT_ZERO)
        |=> !state_q.act_a)
        else $error("out_a changed twice in one period");

    chk_match_irq: assert property ( // see RULE25
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode != MODE_IDLE) && tick && (count_next == cmp_a_m)
        |=> match_a_irq ##1 !match_a_irq)
        else $error("compare_a match did not pulse its request");

    chk_match_inactive: assert property ( // see RULE23
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_PWM) && tick && !state_q.done_a &&
        (count_next == cmp_a_m) && (count_next != CNT_ZERO)
        |=> !state_q.act_a && state_q.done_a)
        else $error("out_a not inactive on its first match");

    chk_pulse_b_idle: assert property ( // see RULE12
        @(posedge clk) disable iff (!rst_b)
        (state_q.mode == MODE_PULSE) && (state_d.mode == MODE_PULSE)
        |=> !state_q.act_b)
        else $error("out_b active in pulse mode");

endmodule : timer_pwm_ppg_output

// *** include/pwm_ppg_pkg.sv ***
// Purpose: Shared constants, types and helpers for the PWM/pulse timer.
// Assumes: 25 MHz clk, plain register port with one-cycle read latency.
// Notes: Register byte offsets, control layout and reset values live here.
package pwm_ppg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int SEL_W = 4;
    localparam int PRE_W = 11;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMP_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CMP_B = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

    // Count clock divider: base divide, largest selector code
    localparam logic [PRE_W-1:0] PRE_BASE = 11'h008;
    localparam logic [PRE_W-1:0] PRE_ONE = 11'h001;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'h8;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
    localparam logic [CNT_W-1:0] BYTE_TOP = 16'h00ff;
    localparam logic [CNT_W-1:0] WORD_TOP = 16'hffff;
    localparam logic [7:0] HIGH_ZERO = 8'h00;

    // Pin level while reset (output disabled, select bits zero)
    localparam logic OUT_RST = 1'b1;

    // Status word: count in low half, active flags above
    localparam int STAT_ACT_A = 16;
    localparam int STAT_ACT_B = 17;

    typedef struct packed {
        logic [SEL_W-1:0] prescale_sel;  // bits 12:9
        logic active_level_b;            // bit 8
        logic output_enable_b;           // bit 7
        logic active_level_a;            // bit 6
        logic output_enable_a;           // bit 5
        logic compare_mode_select;       // bit 4
        logic clear_on_capture;          // bit 3
        logic clear_on_compare_b;        // bit 2
        logic count_width_select;        // bit 1
        logic count_run;                 // bit 0
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Gray path: idle -> pwm -> programmable_pulse
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_PWM = 2'b01,
        MODE_PULSE = 2'b11
    } mode_t;

    // Fold a value to the selected counter width
    function automatic logic [CNT_W-1:0] width_mask(
        input logic [CNT_W-1:0] val,
        input logic wide
    );
        width_mask = wide ? val : {HIGH_ZERO, val[7:0]};
    endfunction : width_mask

    // Pin level from enable, level select and logical active state
    function automatic logic pin_level(
        input logic enable,
        input logic alv,
        input logic active
    );
        if (!enable) begin
            pin_level = ~alv;
        end else begin
            pin_level = active ? ~alv : alv;
        end
    endfunction : pin_level

endpackage : pwm_ppg_pkg

// *** rtl/count_prescaler.sv ***
// Purpose: Divides clk into the timer count clock (8 to 2048).
// Assumes: Selector codes 0..8; larger codes clamp to the slowest divide.
// Notes: Tick is a one-cycle pulse; the divider restarts while stopped.
module count_prescaler
    import pwm_ppg_pkg::*;
(
    input wire logic clk,                 // System clock
    input wire logic rst_b,               // Async reset, active low
    input wire logic run,                 // Counting enabled
    input wire logic [SEL_W-1:0] sel,     // Divide selector
    output logic tick                     // Count clock pulse
);

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } pre_state_t;

    pre_state_t state_q;
    pre_state_t state_d;

    function automatic logic [PRE_W-1:0] div_limit(
        input logic [SEL_W-1:0] code
    );
        logic [SEL_W-1:0] c;
        c = (code > SEL_MAX) ? SEL_MAX : code;
        div_limit = PRE_W'(PRE_BASE << c);
    endfunction : div_limit

    always_comb begin
        state_d = state_q;
        state_d.tick = 1'b0;
        if (!run) begin
            state_d.cnt = '0;
        end else if (state_q.cnt == div_limit(sel) - PRE_ONE) begin
            state_d.cnt = '0;
            state_d.tick = 1'b1;
        end else begin
            state_d.cnt = state_q.cnt + PRE_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tick = state_q.tick;

endmodule : count_prescaler

// *** tb/pin_load.sv ***
// Purpose: External load on one timer output pin; measures the waveform.
// Assumes: Pin is a registered level that changes just after clk rises.
// Notes: Lengths are in clk cycles between sampled edges of the pin.
module pin_load (
    input wire logic clk,              // System clock
    input wire logic rst_b,            // Async reset, active low
    input wire logic pin,              // Timer output pin
    output logic [15:0] high_len,      // Last completed high time
    output logic [15:0] period_len,    // Last rise-to-rise time
    output logic [7:0] rises,          // Rising edges seen
    output logic [7:0] falls           // Falling edges seen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_q;
    logic [15:0] cnt_q;
    logic [15:0] hcnt_q;

    // Reset level of the pin is high, so no false rise after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b1;
            cnt_q <= 16'h0000;
            hcnt_q <= 16'h0000;
            high_len <= 16'h0000;
            period_len <= 16'h0000;
            rises <= 8'h00;
            falls <= 8'h00;
        end else begin
            prev_q <= pin;
            cnt_q <= cnt_q + 16'h0001;
            if (pin) begin
                hcnt_q <= hcnt_q + 16'h0001;
            end
            if (pin && !prev_q) begin
                period_len <= cnt_q;
                cnt_q <= 16'h0001;
                hcnt_q <= 16'h0001;
                rises <= rises + 8'h01;
            end
            if (!pin && prev_q) begin
                high_len <= hcnt_q;
                falls <= falls + 8'h01;
            end
        end
    end
endmodule : pin_load

// *** tb/timer_pwm_ppg_output_test.sv ***
// Purpose: Self-checking bench for the PWM and pulse timer outputs.
// Assumes: clk 25 MHz; register port with one-cycle read data.
// Notes: Waveforms are measured by two pin loads in clk cycles.
module timer_pwm_ppg_output_test
    import pwm_ppg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst_b;
    reg_req_t req;
    logic [DATA_W-1:0] rdata;
    logic out_a;
    logic out_b;
    logic irq_a;
    logic irq_b;
    logic [15:0] a_high, a_per, b_high, b_per;
    logic [7:0] a_rises, a_falls, b_rises, b_falls;
    int n_fail = 0;
    int samples_checked = 0;
    int na = 0;
    int nb = 0;
    int na0, nb0;
    logic [31:0] d;

    timer_pwm_ppg_output i_dut (.clk(clk), .rst_b(rst_b), .req(req),
        .rdata(rdata), .out_a(out_a), .out_b(out_b),
        .match_a_irq(irq_a), .match_b_irq(irq_b));
    pin_load i_load_a (.clk(clk), .rst_b(rst_b), .pin(out_a),
        .high_len(a_high), .period_len(a_per), .rises(a_rises),
        .falls(a_falls));
    pin_load i_load_b (.clk(clk), .rst_b(rst_b), .pin(out_b),
        .high_len(b_high), .period_len(b_per), .rises(b_rises),
        .falls(b_falls));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (irq_a === 1'b1) na++;
        if (irq_b === 1'b1) nb++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic give_up;
        n_fail++;
        $display("Error at %0t: wait ran out", $time);
        test_done();
    endtask : give_up

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    // Poll the running count until it reaches a value
    task automatic wait_count(input logic [15:0] v);
        logic [31:0] s;
        for (int i = 0; i < 3000; i++) begin
            rd(OFF_STATUS, s);
            if (s[15:0] >= v) return;
        end
        give_up();
    endtask : wait_count

    // Wait for the next rise (or fall) of out_a as seen by its load
    task automatic wait_a(input bit fall);
        logic [7:0] r0;
        r0 = fall ? a_falls : a_rises;
        repeat (5000) begin
            @(posedge clk);
            #1;
            if ((fall ? a_falls : a_rises) != r0) return;
        end
        give_up();
    endtask : wait_a

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        req = '0;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(32'(out_a), 32'h1);
        chk(32'(out_b), 32'h1);
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i), d);
            // Stopped timer holds both outputs logically active
            chk(d, (i == 3) ? 32'h0003_0000 : 32'h0);
        end
        // Disabled pins with level select 1 sit low
        wr(OFF_CTRL, 32'h140);
        settle();
        chk(32'(out_a), 32'h0);
        chk(32'(out_b), 32'h0);
        rd(OFF_CTRL, d);
        chk(d, 32'h140);
        // Eight-bit PWM, divide by 8
        wr(OFF_CMP_A, 32'h2);
        wr(OFF_CMP_B, 32'h5);
        wr(OFF_CTRL, 32'ha1);
        wait_a(0);
        wait_a(0);
        chk(32'(a_per), 32'd2048);
        chk(32'(a_high), 32'd16);
        chk(32'(b_high), 32'd40);
        na0 = na;
        nb0 = nb;
        wait_a(0);
        chk(32'(na - na0), 32'h1);
        chk(32'(nb - nb0), 32'h1);
        // Lower compare below count: active across the wrap
        wr(OFF_CMP_A, 32'h80);
        wait_count(16'h0040);
        wr(OFF_CMP_A, 32'h20);
        wait_a(1);
        chk(32'(a_high), 32'd2304);
        wr(OFF_CTRL, 32'ha0);
        settle();
        chk(32'(out_a), 32'h1);
        chk(32'(out_b), 32'h1);
        rd(OFF_STATUS, d);
        chk(d, 32'h0003_0000);
        // Pulse mode at three count clock rates
        for (int s = 0; s < 3; s++) begin
            wr(OFF_CTRL, 32'h0);
            wr(OFF_CMP_A, 32'h3);
            wr(OFF_CMP_B, 32'h9);
            wr(OFF_CTRL, 32'ha5 | (s << 9));
            wait_a(0);
            wait_a(0);
            chk(32'(a_per), 32'(10 * (8 << s)));
            chk(32'(a_high), 32'(3 * (8 << s)));
            chk(32'(out_b), 32'h0);
            na0 = na;
            nb0 = nb;
            wait_a(0);
            chk(32'(na - na0), 32'h1);
            chk(32'(nb - nb0), 32'h1);
        end
        // Cut the period below the count before the width match
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CMP_A, 32'h30);
        wr(OFF_CMP_B, 32'h40);
        wr(OFF_CTRL, 32'h25);
        wait_a(0);
        wait_count(16'h0028);
        wr(OFF_CMP_B, 32'h20);
        wait_a(0);
        chk(32'(a_per), 32'd2048);
        chk(32'(a_high), 32'd384);
        // Sixteen-bit PWM runs past 255
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CMP_A, 32'h200);
        wr(OFF_CTRL, 32'h23);
        wait_count(16'h0120);
        chk(32'(out_a), 32'h1);
        wait_count(16'h0210);
        chk(32'(out_a), 32'h0);
        test_done();
    end
endmodule : timer_pwm_ppg_output_test
